// >>> common/sps_cfg.svh
// sps_cfg.svh: register map, field positions, defaults and timing of the
// pulse sequencer. Assumes a 40 MHz clock and byte addresses on AHB-Lite.
`ifndef SPS_CFG_SVH
`define SPS_CFG_SVH
// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define SPS_A_CMD  8'h00
`define SPS_A_CFG  8'h04
`define SPS_A_PER  8'h08
`define SPS_A_WID  8'h0C
`define SPS_A_CNT  8'h10
`define SPS_A_C0C  8'h14
`define SPS_A_C0L  8'h18
`define SPS_A_C1C  8'h1C
`define SPS_A_C1L  8'h20
`define SPS_A_SEGN 8'h24
`define SPS_A_SIDX 8'h28
`define SPS_A_SLVL 8'h2C
`define SPS_A_SCTL 8'h30
`define SPS_A_STAT 8'h34
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SPS_CMD_ON    0
`define SPS_CMD_OFF   1
`define SPS_CMD_APPLY 2
`define SPS_CMD_RST   3
`define SPS_CMD_CLR   4
`define SPS_CFG_IMM   0
`define SPS_CFG_SEG   1
`define SPS_CFG_BURST 2
`define SPS_CFG_EXT   3
`define SPS_CFG_PERP  4
`define SPS_CFG_FALL  5
`define SPS_CFG_NEG   6
`define SPS_CFG_MAST  7
`define SPS_CH_EN     0
`define SPS_CH_FIX    1
`define SPS_CH_CMP    2
`define SPS_SC_TRG    24
`define SPS_SC_SW     25
// ----------------------------------------------------------------------
// reset values and timing
// ----------------------------------------------------------------------
`define SPS_DEF_CFG  8'h00
`define SPS_DEF_PER  32'h0000_0028
`define SPS_DEF_WID  32'h0000_0014
`define SPS_DEF_CNT  32'h0000_0001
`define SPS_DEF_HIGH 16'h03E8
`define SPS_DEF_LOW  16'h0000
`define SPS_CLK_NS   32'h0000_0019
`define SPS_STEP_NS  32'h0000_000A
`define SPS_MIN_STEP 24'h00_0002
`define SPS_TAIL_NS  32'h0000_000A
`define SPS_TAIL_CYC ((`SPS_TAIL_NS + `SPS_CLK_NS - 32'h0000_0001) / `SPS_CLK_NS)
`endif

// >>> common/sps_pkg.sv
// sps_pkg: types shared by the sequencer files.
// Assumes sps_cfg.svh supplies all numeric constants.
package sps_pkg;
   typedef enum logic [3:0] {
      SPS_IDLE = 4'b0001,
      SPS_ARM  = 4'b0010,
      SPS_RUN  = 4'b0100,
      SPS_TAIL = 4'b1000
   } sps_state_e;
   // one complete settings set: staged by software, copied to active
   typedef struct packed {
      logic [7:0]        cfg;
      logic [31:0]       per;
      logic [31:0]       wid;
      logic [31:0]       cnt;
      logic [1:0][2:0]   ch;
      logic [1:0][15:0]  hi;
      logic [1:0][15:0]  lo;
   } sps_set_s;
endpackage

// >>> hw/sps_edge.sv
// sps_edge: picks rising or falling edges of the trigger line.
// Assumes the line is synchronous to clk_i.
`timescale 1ns/1ps
module sps_edge (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic sig_i,
   input  wire logic fall_i,
   output logic      hit_o
);
   logic prev_q;
   logic prev_d;
   always_comb begin
      prev_d = sig_i;
      hit_o  = fall_i ? (prev_q & ~sig_i) : (~prev_q & sig_i);
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= prev_d;
      end
   end
endmodule

// >>> hw/sps_chan.sv
// sps_chan: one output channel, picks the level code to drive.
// Assumes phase and segment level come from the sequencer.
`timescale 1ns/1ps
`include "sps_cfg.svh"
module sps_chan #(
   parameter int LW = 16
) (
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic          on_i,
   input  wire logic          seg_i,
   input  wire logic          hiph_i,
   input  wire logic          fix_i,
   input  wire logic          cmp_i,
   input  wire logic [LW-1:0] hi_i,
   input  wire logic [LW-1:0] lo_i,
   input  wire logic [LW-1:0] seg_lvl_i,
   output logic [LW-1:0]      level_o,
   output logic               on_o
);
   logic [LW-1:0] lvl_d;
   logic          on_d;
   always_comb begin
      on_d = on_i;
      if (!on_i) begin
         lvl_d = '0;
      end else if (seg_i) begin
         lvl_d = seg_lvl_i;
      end else if (fix_i) begin
         lvl_d = hi_i;
      end else if (hiph_i) begin
         lvl_d = cmp_i ? lo_i : hi_i;
      end else begin
         lvl_d = cmp_i ? hi_i : lo_i;
      end
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         level_o <= '0;
         on_o    <= 1'b0;
      end else begin
         level_o <= lvl_d;
         on_o    <= on_d;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ch_off;
      !on_i |=> !on_o && level_o == '0;
   endproperty
   a_ch_off: assert property (p_ch_off) else $error("disabled channel drives");
   property p_fixed;
      on_i && !seg_i && fix_i |=> level_o == $past(hi_i);
   endproperty
   a_fixed: assert property (p_fixed) else $error("fixed level not high");
   property p_comp;
      on_i && !seg_i && !fix_i && cmp_i && hiph_i |=> level_o == $past(lo_i);
   endproperty
   a_comp: assert property (p_comp) else $error("complement high not low");
endmodule

// >>> hw/sps_top.sv
// sps_top: pulse sequencer of a two-channel pulse card with AHB-Lite
// register slave. Assumes a single clock, synchronous trigger input and
// one AHB-Lite master with zero-wait single word transfers.
//
// Contract
// - master trigger output can start all cards
// - polarity change toggles trigger output level
// - four external trigger behaviours supported
// - continuous and burst; count only in burst
// - fixed-level mode holds pulse-high level
// - complement mode swaps high and low levels
// - default high 1 V, low 0 V
// - only enabled channels produce output
// - one on command starts all, off stops
// - immediate apply or explicit apply command
// - reset-all restores standard pulse and defaults
// - 10 ns hold after last segment; held for one 25 ns clock here
// - segment duration multiple of 10 ns, min 20
// - segments hold start, stop, duration; in order
// - segment trigger bit drives trigger output
// - segment switch bit drives output switch
//
// Chosen here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "sps_cfg.svh"
module sps_top #(
   parameter int SEGS = 16
) (
   input  wire logic        CLK_I,
   input  wire logic        RST_I,
   input  wire logic        HSEL_I,
   input  wire logic [31:0] HADDR_I,
   input  wire logic [1:0]  HTRANS_I,
   input  wire logic        HWRITE_I,
   input  wire logic [2:0]  HSIZE_I,
   input  wire logic [31:0] HWDATA_I,
   input  wire logic        HREADY_I,
   output logic [31:0]      HRDATA_O,
   output logic             HREADYOUT_O,
   output logic             HRESP_O,
   input  wire logic        TRIG_I,
   output logic             TRIG_O,
   output logic             SWITCH_O,
   output logic [15:0]      CH0_LEVEL_O,
   output logic [15:0]      CH1_LEVEL_O,
   output logic             CH0_ON_O,
   output logic             CH1_ON_O
);
   localparam int SW = $clog2(SEGS);
   localparam sps_pkg::sps_set_s DEF = '{
      cfg: `SPS_DEF_CFG,
      per: `SPS_DEF_PER,
      wid: `SPS_DEF_WID,
      cnt: `SPS_DEF_CNT,
      ch:  '0,
      hi:  {`SPS_DEF_HIGH, `SPS_DEF_HIGH},
      lo:  {`SPS_DEF_LOW, `SPS_DEF_LOW}
   };

   // ----------------------------------------------------------------------
   // AHB-Lite slave: zero wait states, always OKAY
   // ----------------------------------------------------------------------
   logic        take;
   logic        wr_q;
   logic        wr_d;
   logic [7:0]  wa_q;
   logic [7:0]  wa_d;
   logic [31:0] rd_q;
   logic [31:0] rd_d;
   logic [31:0] rv;

   sps_pkg::sps_set_s  stg_q;
   sps_pkg::sps_set_s  stg_d;
   sps_pkg::sps_set_s  act_q;
   sps_pkg::sps_set_s  act_d;
   sps_pkg::sps_state_e st_q;
   sps_pkg::sps_state_e st_d;
   logic [31:0] slv_q [SEGS];
   logic [31:0] slv_d [SEGS];
   logic [25:0] sct_q [SEGS];
   logic [25:0] sct_d [SEGS];
   logic [SW:0]   sn_q;
   logic [SW:0]   sn_d;
   logic [SW-1:0] si_q;
   logic [SW-1:0] si_d;
   logic [SW-1:0] seg_q;
   logic [SW-1:0] seg_d;
   logic [31:0] cyc_q;
   logic [31:0] cyc_d;
   logic [31:0] pul_q;
   logic [31:0] pul_d;
   logic        on_q;
   logic        on_d;
   logic        done_q;
   logic        done_d;
   logic        rej_q;
   logic        rej_d;
   logic        hi_q;
   logic        hi_d;
   logic        tout_q;
   logic        tout_d;
   logic        sw_q;
   logic        sw_d;
   logic        trg_d;

   assign take = HSEL_I & HTRANS_I[1] & HREADY_I;

   always_comb begin
      rv = 32'h0000_0000;
      case (HADDR_I[7:0])
         `SPS_A_CFG:  rv = {24'h00_0000, stg_q.cfg};
         `SPS_A_PER:  rv = stg_q.per;
         `SPS_A_WID:  rv = stg_q.wid;
         `SPS_A_CNT:  rv = stg_q.cnt;
         `SPS_A_C0C:  rv = {29'h0000_0000, stg_q.ch[0]};
         `SPS_A_C0L:  rv = {stg_q.lo[0], stg_q.hi[0]};
         `SPS_A_C1C:  rv = {29'h0000_0000, stg_q.ch[1]};
         `SPS_A_C1L:  rv = {stg_q.lo[1], stg_q.hi[1]};
         `SPS_A_SEGN: rv = 32'(sn_q);
         `SPS_A_SIDX: rv = 32'(si_q);
         `SPS_A_SLVL: rv = slv_q[si_q];
         `SPS_A_SCTL: rv = {6'h00, sct_q[si_q]};
         `SPS_A_STAT: rv = {pul_q[15:0], 8'(seg_q), 1'b0, rej_q, done_q, on_q, st_q};
         default:     rv = 32'h0000_0000;
      endcase
      wr_d = take & HWRITE_I;
      wa_d = HADDR_I[7:0];
      rd_d = (take & ~HWRITE_I) ? rv : rd_q;
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         wr_q        <= 1'b0;
         wa_q        <= 8'h00;
         rd_q        <= 32'h0000_0000;
         HREADYOUT_O <= 1'b1;
         HRESP_O     <= 1'b0;
      end else begin
         wr_q        <= wr_d;
         wa_q        <= wa_d;
         rd_q        <= rd_d;
         HREADYOUT_O <= 1'b1;
         HRESP_O     <= 1'b0;
      end
   end
   assign HRDATA_O = rd_q;

   // ----------------------------------------------------------------------
   // settings: staged copy, active copy, segment table
   // ----------------------------------------------------------------------
   logic c_on;
   logic c_off;
   logic c_app;
   logic c_rst;
   logic c_clr;
   logic bad_dur;
   assign c_on  = wr_q && wa_q == `SPS_A_CMD && HWDATA_I[`SPS_CMD_ON];
   assign c_off = wr_q && wa_q == `SPS_A_CMD && HWDATA_I[`SPS_CMD_OFF];
   assign c_app = wr_q && wa_q == `SPS_A_CMD && HWDATA_I[`SPS_CMD_APPLY];
   assign c_rst = wr_q && wa_q == `SPS_A_CMD && HWDATA_I[`SPS_CMD_RST];
   assign c_clr = wr_q && wa_q == `SPS_A_CMD && HWDATA_I[`SPS_CMD_CLR];
   assign bad_dur = wr_q && wa_q == `SPS_A_SCTL && HWDATA_I[23:0] < `SPS_MIN_STEP;

   always_comb begin
      stg_d = stg_q;
      act_d = act_q;
      slv_d = slv_q;
      sct_d = sct_q;
      sn_d  = sn_q;
      si_d  = si_q;
      rej_d = (rej_q & ~c_clr) | bad_dur;
      if (wr_q) begin
         case (wa_q)
            `SPS_A_CFG:  stg_d.cfg = HWDATA_I[7:0];
            `SPS_A_PER:  stg_d.per = HWDATA_I;
            `SPS_A_WID:  stg_d.wid = HWDATA_I;
            `SPS_A_CNT:  stg_d.cnt = HWDATA_I;
            `SPS_A_C0C:  stg_d.ch[0] = HWDATA_I[2:0];
            `SPS_A_C0L:  {stg_d.lo[0], stg_d.hi[0]} = HWDATA_I;
            `SPS_A_C1C:  stg_d.ch[1] = HWDATA_I[2:0];
            `SPS_A_C1L:  {stg_d.lo[1], stg_d.hi[1]} = HWDATA_I;
            `SPS_A_SEGN: sn_d = (HWDATA_I[SW:0] == '0) ? (SW+1)'(1) : HWDATA_I[SW:0];
            `SPS_A_SIDX: si_d = HWDATA_I[SW-1:0];
            `SPS_A_SLVL: slv_d[si_q] = HWDATA_I;
            `SPS_A_SCTL: begin
               // short durations are dropped whole, the old entry stays
               if (!bad_dur) begin
                  sct_d[si_q] = HWDATA_I[25:0];
               end
            end
            default: ;
         endcase
      end
      if (c_app || (act_q.cfg[`SPS_CFG_IMM] && on_q)) begin
         act_d = stg_q;
      end
      if (c_rst) begin
         stg_d = DEF;
         act_d = DEF;
         sn_d  = (SW+1)'(1);
         si_d  = '0;
         for (int i = 0; i < SEGS; i++) begin
            slv_d[i] = 32'h0000_0000;
            sct_d[i] = 26'(`SPS_MIN_STEP);
         end
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         stg_q <= DEF;
         act_q <= DEF;
         sn_q  <= (SW+1)'(1);
         si_q  <= '0;
         rej_q <= 1'b0;
         for (int i = 0; i < SEGS; i++) begin
            slv_q[i] <= 32'h0000_0000;
            sct_q[i] <= 26'(`SPS_MIN_STEP);
         end
      end else begin
         stg_q <= stg_d;
         act_q <= act_d;
         sn_q  <= sn_d;
         si_q  <= si_d;
         rej_q <= rej_d;
         slv_q <= slv_d;
         sct_q <= sct_d;
      end
   end

   // ----------------------------------------------------------------------
   // trigger source: a master listens to its own output
   // ----------------------------------------------------------------------
   logic tsrc;
   logic hit;
   assign tsrc = act_q.cfg[`SPS_CFG_MAST] ? TRIG_O : TRIG_I;

   sps_edge u_edge (
      .clk_i  (CLK_I),
      .rst_i  (RST_I),
      .sig_i  (tsrc),
      .fall_i (act_q.cfg[`SPS_CFG_FALL]),
      .hit_o  (hit)
   );

   // ----------------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------------
   logic        ext;
   logic        segm;
   logic        fin;
   logic        last;
   logic [31:0] dur_ns;
   assign ext    = act_q.cfg[`SPS_CFG_EXT];
   assign segm   = act_q.cfg[`SPS_CFG_SEG];
   assign last   = 32'(seg_q) + 32'h0000_0001 >= 32'(sn_q);
   assign dur_ns = 32'(sct_q[seg_q][23:0]) * `SPS_STEP_NS;

   always_comb begin
      st_d   = st_q;
      cyc_d  = cyc_q;
      pul_d  = pul_q;
      seg_d  = seg_q;
      tout_d = tout_q;
      sw_d   = sw_q;
      fin    = 1'b0;
      on_d   = (on_q | c_on) & ~c_off & ~c_rst;
      done_d = done_q & ~c_on;
      case (st_q)
         sps_pkg::SPS_IDLE: begin
            if (on_q && !done_q) begin
               st_d  = ext ? sps_pkg::SPS_ARM : sps_pkg::SPS_RUN;
               cyc_d = 32'h0000_0000;
               pul_d = 32'h0000_0000;
               seg_d = '0;
            end
         end
         sps_pkg::SPS_ARM: begin
            if (hit) begin
               st_d  = sps_pkg::SPS_RUN;
               cyc_d = 32'h0000_0000;
               seg_d = '0;
            end
         end
         sps_pkg::SPS_RUN: begin
            if (segm) begin
               cyc_d = cyc_q + `SPS_CLK_NS;
               if (cyc_q + `SPS_CLK_NS >= dur_ns) begin
                  cyc_d = 32'h0000_0000;
                  if (last) begin
                     st_d = sps_pkg::SPS_TAIL;
                  end else begin
                     seg_d = seg_q + 1'b1;
                  end
               end
            end else if (cyc_q + 32'h0000_0001 >= act_q.per) begin
               fin = 1'b1;
            end else begin
               cyc_d = cyc_q + 32'h0000_0001;
            end
         end
         sps_pkg::SPS_TAIL: begin
            // tout and switch are left alone: they keep the last segment
            if (cyc_q + 32'h0000_0001 >= `SPS_TAIL_CYC) begin
               fin = 1'b1;
            end else begin
               cyc_d = cyc_q + 32'h0000_0001;
            end
         end
         default: st_d = sps_pkg::SPS_IDLE;
      endcase
      if (fin) begin
         pul_d = pul_q + 32'h0000_0001;
         cyc_d = 32'h0000_0000;
         seg_d = '0;
         if (act_q.cfg[`SPS_CFG_BURST] && pul_q + 32'h0000_0001 >= act_q.cnt) begin
            st_d   = sps_pkg::SPS_IDLE;
            done_d = 1'b1;
         end else if (ext && act_q.cfg[`SPS_CFG_PERP]) begin
            st_d = sps_pkg::SPS_ARM;
         end else begin
            st_d = sps_pkg::SPS_RUN;
         end
      end
      if (!on_q) begin
         st_d = sps_pkg::SPS_IDLE;
      end
      hi_d = st_d == sps_pkg::SPS_RUN && !segm && cyc_d < act_q.wid;
      if (!segm) begin
         tout_d = hi_d;
         sw_d   = on_q;
      end else if (st_d == sps_pkg::SPS_RUN) begin
         tout_d = sct_q[seg_d][`SPS_SC_TRG];
         sw_d   = sct_q[seg_d][`SPS_SC_SW];
      end else if (st_d != sps_pkg::SPS_TAIL) begin
         tout_d = 1'b0;
         sw_d   = 1'b0;
      end
      trg_d = tout_q ^ act_q.cfg[`SPS_CFG_NEG];
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         st_q     <= sps_pkg::SPS_IDLE;
         cyc_q    <= 32'h0000_0000;
         pul_q    <= 32'h0000_0000;
         seg_q    <= '0;
         on_q     <= 1'b0;
         done_q   <= 1'b0;
         hi_q     <= 1'b0;
         tout_q   <= 1'b0;
         sw_q     <= 1'b0;
         TRIG_O   <= 1'b0;
         SWITCH_O <= 1'b0;
      end else begin
         st_q     <= st_d;
         cyc_q    <= cyc_d;
         pul_q    <= pul_d;
         seg_q    <= seg_d;
         on_q     <= on_d;
         done_q   <= done_d;
         hi_q     <= hi_d;
         tout_q   <= tout_d;
         sw_q     <= sw_d;
         TRIG_O   <= trg_d;
         SWITCH_O <= sw_q;
      end
   end

   // ----------------------------------------------------------------------
   // channels
   // ----------------------------------------------------------------------
   logic [15:0] seg_lvl;
   logic [15:0] lvl [2];
   logic        chon [2];
   // before a run starts the channel rests at the first start level
   assign seg_lvl = (st_q == sps_pkg::SPS_RUN || st_q == sps_pkg::SPS_TAIL) ?
                    slv_q[seg_q][31:16] : slv_q[0][15:0];

   for (genvar c = 0; c < 2; c++) begin : g_ch
      sps_chan #(.LW(16)) u_ch (
         .clk_i     (CLK_I),
         .rst_i     (RST_I),
         .on_i      (on_q & act_q.ch[c][`SPS_CH_EN]),
         .seg_i     (segm),
         .hiph_i    (hi_q),
         .fix_i     (act_q.ch[c][`SPS_CH_FIX]),
         .cmp_i     (act_q.ch[c][`SPS_CH_CMP]),
         .hi_i      (act_q.hi[c]),
         .lo_i      (act_q.lo[c]),
         .seg_lvl_i (seg_lvl),
         .level_o   (lvl[c]),
         .on_o      (chon[c])
      );
   end
   assign CH0_LEVEL_O = lvl[0];
   assign CH1_LEVEL_O = lvl[1];
   assign CH0_ON_O    = chon[0];
   assign CH1_ON_O    = chon[1];

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);

   property p_master;
      on_q && st_q == sps_pkg::SPS_ARM && act_q.cfg[`SPS_CFG_MAST] &&
      !act_q.cfg[`SPS_CFG_FALL] && !$past(TRIG_O) && TRIG_O |=> st_q == sps_pkg::SPS_RUN;
   endproperty
   a_master: assert property (p_master) else $error("master edge missed");
   property p_pol;
      $changed(act_q.cfg[`SPS_CFG_NEG]) && $stable(tout_q) |=> $changed(TRIG_O);
   endproperty
   a_pol: assert property (p_pol) else $error("polarity did not toggle");
   property p_perp;
      on_q && fin && ext && act_q.cfg[`SPS_CFG_PERP] && !act_q.cfg[`SPS_CFG_BURST]
      |=> st_q == sps_pkg::SPS_ARM;
   endproperty
   a_perp: assert property (p_perp) else $error("per-pulse did not re-arm");
   sequence s_last;
      on_q && fin && act_q.cfg[`SPS_CFG_BURST] && pul_q + 32'h0000_0001 >= act_q.cnt;
   endsequence
   property p_burst;
      s_last ##1 !c_on [*2] |=> st_q == sps_pkg::SPS_IDLE && done_q;
   endproperty
   a_burst: assert property (p_burst) else $error("burst did not stop");
   property p_onoff;
      (c_on && !c_off && !c_rst |=> on_q) and (c_off |=> !on_q);
   endproperty
   a_onoff: assert property (p_onoff) else $error("output command ignored");
   property p_imm;
      on_q && act_q.cfg[`SPS_CFG_IMM] && !c_rst |=> act_q.per == $past(stg_q.per);
   endproperty
   a_imm: assert property (p_imm) else $error("immediate apply lost");
   property p_rst;
      c_rst |=> act_q.hi[0] == `SPS_DEF_HIGH && act_q.lo[1] == `SPS_DEF_LOW && !segm && !on_q;
   endproperty
   a_rst: assert property (p_rst) else $error("reset-all not default");
   sequence s_tail;
      on_q && st_q == sps_pkg::SPS_TAIL;
   endsequence
   property p_tail;
      s_tail |-> $stable(tout_q) && $stable(sw_q) && $past(st_q) != sps_pkg::SPS_IDLE;
   endproperty
   a_tail: assert property (p_tail) else $error("tail did not hold");
   property p_dur;
      bad_dur |=> rej_q && sct_q[$past(si_q)] == $past(sct_q[si_q]);
   endproperty
   a_dur: assert property (p_dur) else $error("short duration accepted");
   property p_segtrg;
      on_q && segm && st_q == sps_pkg::SPS_RUN && $stable(sct_q[seg_q])
      |=> TRIG_O == ($past(sct_q[seg_q][`SPS_SC_TRG]) ^ $past(act_q.cfg[`SPS_CFG_NEG]));
   endproperty
   a_segtrg: assert property (p_segtrg) else $error("segment trigger wrong");
endmodule

// >>> dv/sps_sub_model.sv
// sps_sub_model: subordinate card sharing the trigger line.
// assumes fire_i is held by the bench, synchronous to clk_i.
`timescale 1ns/1ps
module sps_sub_model (
   input  wire logic clk_i,
   input  wire logic fire_i,
   input  wire logic mtrig_i,
   output logic      line_o,
   output logic [7:0] edges_o
);
   logic       line_q = 1'b0;
   logic       last_q = 1'b0;
   logic [7:0] edges_q = 8'h00;
   assign line_o  = line_q;
   assign edges_o = edges_q;
   // idle line rests low, as a pulled-down logic line
   always @(posedge clk_i) begin
      line_q <= fire_i;
      last_q <= mtrig_i;
      // any master level change looks like a trigger here
      if (mtrig_i != last_q) edges_q <= edges_q + 8'h01;
   end
endmodule

// >>> dv/test_segmented_pulse_sequencer.sv
// test_segmented_pulse_sequencer: register, pulse, segment and trigger tests.
// assumes a zero-wait AHB-Lite slave and the subordinate model on TRIG_I.
`timescale 1ns/1ps
`include "sps_cfg.svh"
module test_segmented_pulse_sequencer;
   typedef struct packed {logic [7:0] a; logic [31:0] v;} sps_row_s;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0]  htrans = 2'b00;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata, rd;
   logic        hrdy, hresp, trig_o, sw, on0, on1, line;
   logic        fire = 1'b0;
   logic [15:0] lv0, lv1;
   logic [7:0]  edges;
   int          bad_count = 0;
   int          total_checks = 0;
   int          n, n0, nt, ns, nx;
   sps_row_s    rows [10] = '{'{`SPS_A_CFG, 32'h0000_0000}, '{`SPS_A_PER, `SPS_DEF_PER},
      '{`SPS_A_WID, `SPS_DEF_WID}, '{`SPS_A_CNT, `SPS_DEF_CNT}, '{`SPS_A_C0C, 32'h0000_0000},
      '{`SPS_A_C0L, {`SPS_DEF_LOW, `SPS_DEF_HIGH}}, '{`SPS_A_C1L, {`SPS_DEF_LOW, `SPS_DEF_HIGH}},
      '{`SPS_A_SEGN, 32'h0000_0001}, '{`SPS_A_STAT, 32'h0000_0001}, '{8'h3C, 32'h0000_0000}};
   sps_top #(.SEGS(4)) u_dut (.CLK_I(clk), .RST_I(rst), .HSEL_I(1'b1), .HADDR_I(haddr),
      .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'b010), .HWDATA_I(hwdata),
      .HREADY_I(hrdy), .HRDATA_O(hrdata), .HREADYOUT_O(hrdy), .HRESP_O(hresp),
      .TRIG_I(line), .TRIG_O(trig_o), .SWITCH_O(sw), .CH0_LEVEL_O(lv0),
      .CH1_LEVEL_O(lv1), .CH0_ON_O(on0), .CH1_ON_O(on1));
   sps_sub_model u_sub (.clk_i(clk), .fire_i(fire), .mtrig_i(trig_o), .line_o(line),
      .edges_o(edges));
   initial begin
      forever #12.5 clk = ~clk;
   end
   task automatic stop_test();
      if (bad_count == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      haddr  <= {24'h00_0000, a};
      hwrite <= wr;
      htrans <= 2'b10;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask
   task automatic w(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   // counts settled output cycles over a window
   task automatic watch(input int cyc, input logic [15:0] v);
      n0 = 0;
      nt = 0;
      ns = 0;
      nx = 0;
      repeat (cyc) begin
         @(negedge clk);
         n0 += int'(lv0 === v);
         nt += int'(trig_o === 1'b1);
         ns += int'(sw === 1'b1);
         nx += int'(lv0 === 16'h03E8 && lv1 !== 16'h0000);
      end
      @(posedge clk);
   endtask
   initial begin
      #(25 * 6000);
      bad_count++;
      stop_test();
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      foreach (rows[i]) begin
         bus(1'b0, rows[i].a, hwdata);
         check("reg", rd, rows[i].v);
      end
      w(`SPS_A_PER, 32'h0000_0004);
      w(`SPS_A_WID, 32'h0000_0002);
      w(`SPS_A_CNT, 32'h0000_0003);
      w(`SPS_A_CFG, 32'h0000_0004);
      w(`SPS_A_C0C, 32'h0000_0001);
      w(`SPS_A_C1C, 32'h0000_0005);
      w(`SPS_A_CMD, 32'h0000_0004);
      w(`SPS_A_CMD, 32'h0000_0001);
      watch(40, 16'h03E8);
      check("burst highs", n0, 6);
      check("complement", nx, 0);
      w(`SPS_A_CMD, 32'h0000_0002);
      w(`SPS_A_CFG, 32'h0000_0001);
      w(`SPS_A_C0C, 32'h0000_0003);
      w(`SPS_A_C1C, 32'h0000_0000);
      // apply and on together: immediate apply only acts once it is active
      w(`SPS_A_CMD, 32'h0000_0005);
      repeat (4) @(posedge clk);
      watch(20, 16'h03E8);
      check("fixed", n0, 20);
      check("ch1 off", on1, 1'b0);
      w(`SPS_A_C0C, 32'h0000_0001);
      repeat (4) @(posedge clk);
      watch(40, 16'h03E8);
      check("continuous", n0, 20);
      check("ch0 on", on0, 1'b1);
      w(`SPS_A_CMD, 32'h0000_0002);
      repeat (4) @(posedge clk);
      check("ch0 off", on0, 1'b0);
      w(`SPS_A_SEGN, 32'h0000_0002);
      w(`SPS_A_SIDX, 32'h0000_0000);
      w(`SPS_A_SLVL, 32'h01F4_0000);
      w(`SPS_A_SCTL, 32'h0300_0002);
      w(`SPS_A_SIDX, 32'h0000_0001);
      w(`SPS_A_SLVL, 32'h0000_01F4);
      w(`SPS_A_SCTL, 32'h0000_0004);
      // below the minimum: must be dropped
      w(`SPS_A_SCTL, 32'h0000_0001);
      bus(1'b0, `SPS_A_STAT, hwdata);
      check("reject", rd[6], 1'b1);
      w(`SPS_A_CFG, 32'h0000_0002);
      w(`SPS_A_CMD, 32'h0000_0004);
      w(`SPS_A_CMD, 32'h0000_0001);
      repeat (6) @(posedge clk);
      watch(40, 16'h01F4);
      check("seg level", n0, 10);
      check("seg trig", nt, 10);
      check("seg switch", ns, 10);
      w(`SPS_A_CMD, 32'h0000_0002);
      w(`SPS_A_CFG, 32'h0000_000C);
      w(`SPS_A_CMD, 32'h0000_0004);
      w(`SPS_A_CMD, 32'h0000_0001);
      watch(12, 16'h03E8);
      check("armed", n0, 0);
      fire <= 1'b1;
      repeat (2) @(posedge clk);
      fire <= 1'b0;
      watch(40, 16'h03E8);
      check("triggered", n0, 6);
      // per-pulse on falling edges: one period per edge, then re-armed
      w(`SPS_A_CMD, 32'h0000_0002);
      w(`SPS_A_CFG, 32'h0000_0038);
      w(`SPS_A_CMD, 32'h0000_0005);
      fire <= 1'b1;
      repeat (2) @(posedge clk);
      fire <= 1'b0;
      watch(40, 16'h03E8);
      check("per pulse", n0, 2);
      w(`SPS_A_CMD, 32'h0000_0002);
      n = edges;
      w(`SPS_A_CFG, 32'h0000_00E0);
      w(`SPS_A_CMD, 32'h0000_0004);
      repeat (6) @(posedge clk);
      check("polarity edge", edges, n + 1);
      w(`SPS_A_CMD, 32'h0000_0008);
      repeat (2) @(posedge clk);
      bus(1'b0, `SPS_A_CFG, hwdata);
      check("cfg reset", rd, 32'h0000_0000);
      bus(1'b0, `SPS_A_PER, hwdata);
      check("per reset", rd, `SPS_DEF_PER);
      // a hardware reset after reset-all, with the output off, must bring the levels back as well
      w(`SPS_A_C0L, 32'h0000_0005);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      bus(1'b0, `SPS_A_C0L, hwdata);
      check("levels reset", rd, {`SPS_DEF_LOW, `SPS_DEF_HIGH});
      stop_test();
   end
endmodule
